// File: include/ucr_control_regs.vh
/*
 Register map, field positions, reset values and timing counts for the
 upconverter control register bank. Assumes it is included by bare name
 from the core files and that nothing else defines the UCR_ macros.
*/
// Functional notes
// - Control one bit 9 enables output shift keying; reset value disabled.
// - Control one bit 8 picks automatic keying, only while bit 9 set.
// - Control one bit 7 stops digital core clocks immediately, no update.
// - Control one bit 6 powers down main DAC clocks and bias.
// - Control one bit 5 powers down reference input and PLL immediately.
// - Control one bit 4 powers down auxiliary DAC clocks and bias.
// - Control one bit 3 picks full or fast recovery external power-down.
// - Bit 2 with transmit enable low flushes and stops clocks; not single tone.
// - Bit 1 set makes the serial data pin input only, 3-wire mode.
// - Bit 0 sets serial bit order; host must match it.
// - Control two sits at serial address 0x01, four bytes wide.
// - Control two bit 31 turns data pins into dual serial port, quadrature only.
// - Bit 30 sets dual serial port bit order, valid with bit 31.
// - Bit 29 sets dual serial port early frame sync, valid with bit 31.
// - Bit 24 takes amplitude from active profile, single tone, keying off.
// - Bit 23 selects internal or pin-driven I/O update, immediately.
// - Bit 22 enables sync clock at quarter system clock, else static low.
// - Mode field codes quadrature 00, single tone 01, interpolating 1x.
`ifndef UCR_CONTROL_REGS_VH
`define UCR_CONTROL_REGS_VH

`define UCR_ADDR_CF1 5'h00
`define UCR_ADDR_CF2 5'h01
`define UCR_WORD_BITS 6'h20
`define UCR_INSTR_BITS 6'h08
`define UCR_FRAME_BITS 6'h28
`define UCR_INSTR_READ 7
`define UCR_INSTR_ADDR_HI 4

`define UCR_CF1_RESET 32'h00000000
`define UCR_CF2_RESET 32'h00400000
`define UCR_CF1_WMASK 32'h030003FF
`define UCR_CF2_WMASK 32'hE1C00000
`define UCR_CF1_IMASK 32'h000000A0
`define UCR_CF2_IMASK 32'h00800000

`define UCR_CF1_OSK_EN 9
`define UCR_CF1_OSK_AUTO 8
`define UCR_CF1_DIG_PD 7
`define UCR_CF1_DAC_PD 6
`define UCR_CF1_REF_PD 5
`define UCR_CF1_AUX_PD 4
`define UCR_CF1_EXT_FAST 3
`define UCR_CF1_AUTO_PD 2
`define UCR_CF1_IN_ONLY 1
`define UCR_CF1_LSB_FIRST 0
`define UCR_CF1_MODE_HI 25
`define UCR_CF1_MODE_LO 24

`define UCR_CF2_DUAL_EN 31
`define UCR_CF2_DUAL_LSB 30
`define UCR_CF2_DUAL_EARLY 29
`define UCR_CF2_PROF_ASF 24
`define UCR_CF2_INT_UPD 23
`define UCR_CF2_SYNC_EN 22

`define UCR_MODE_QUAD 2'h0
`define UCR_MODE_TONE 2'h1

`define UCR_SYNC_DIV 2'h1
`define UCR_UPDATE_PERIOD 16'h0040

`endif

// File: core/ucr_reg_store.v
/*
 Buffer and active copies of the control words. Writes land in the
 buffer; immediate bits also reach the active copy at once, the rest
 follow on an update pulse. Read data come out of a register one cycle
 after the index. Assumes single-cycle write and update pulses on clk.
*/
`timescale 1ns/100ps
module ucr_reg_store #(
	parameter WIDTH = 32,
	parameter WORDS = 2,
	parameter IW = 1,
	parameter [WORDS*WIDTH-1:0] WMASK = {WORDS*WIDTH{1'b1}},
	parameter [WORDS*WIDTH-1:0] IMASK = {WORDS*WIDTH{1'b0}},
	parameter [WORDS*WIDTH-1:0] RESETV = {WORDS*WIDTH{1'b0}}
) (
	input wire clk,
	input wire rst,
	input wire wr_en,
	input wire [IW-1:0] wr_index,
	input wire [WIDTH-1:0] wr_data,
	input wire update,
	input wire [IW-1:0] rd_index,
	output reg [WIDTH-1:0] rd_data,
	output wire [WORDS*WIDTH-1:0] active_flat
);

wire [WORDS*WIDTH-1:0] buf_flat;

genvar g;
generate
	for (g = 0; g < WORDS; g = g + 1) begin : word
		localparam [WIDTH-1:0] WM = WMASK[g*WIDTH +: WIDTH];
		localparam [WIDTH-1:0] IM = IMASK[g*WIDTH +: WIDTH];
		localparam [WIDTH-1:0] RV = RESETV[g*WIDTH +: WIDTH];
		reg [WIDTH-1:0] buffer;
		reg [WIDTH-1:0] active;
		wire hit;
		assign hit = wr_en && (wr_index == g);
		always @(posedge clk or posedge rst) begin
			if (rst) begin
				buffer <= RV;
				active <= RV;
			end else begin
				if (hit)
					buffer <= wr_data & WM;
				if (hit)
					active <= (active & ~IM) | (wr_data & WM & IM);
				if (update)
					active <= (buffer & ~IM) | (active & IM);
				if (update && hit)
					active <= (buffer & ~IM) | (wr_data & WM & IM);
			end
		end
		assign buf_flat[g*WIDTH +: WIDTH] = buffer;
		assign active_flat[g*WIDTH +: WIDTH] = active;
	end
endgenerate

always @(posedge clk or posedge rst) begin
	if (rst)
		rd_data <= {WIDTH{1'b0}};
	else if (rd_index < WORDS)
		rd_data <= buf_flat[rd_index*WIDTH +: WIDTH];
	else
		rd_data <= {WIDTH{1'b0}};
end

endmodule // ucr_reg_store

// File: core/ucr_control_top.v
/*
 Serial programming port and control bit bank of the upconverter: two
 32-bit control words, their I/O update transfer and the control levels
 that they drive. Assumes the host drives the serial clock well below a
 quarter of clk, so that every pin edge is seen after synchronising.
*/
`timescale 1ns/100ps
`include "ucr_control_regs.vh"
module ucr_control_top #(
	parameter [15:0] UPDATE_PERIOD = `UCR_UPDATE_PERIOD
) (
	input wire clk,
	input wire rst,
	input wire sclk,
	input wire cs_n,
	input wire sdio_in,
	output reg sdio_out,
	output wire sdio_oe,
	output reg sdo,
	input wire io_update_in,
	output reg io_update_out,
	output wire io_update_oe,
	input wire transmit_enable_pin,
	input wire external_powerdown_pin,
	output reg output_shift_keying_en,
	output reg output_shift_keying_auto,
	output reg core_clock_stop,
	output reg dac_powerdown,
	output reg reference_clock_input_powerdown,
	output reg aux_dac_powerdown,
	output reg full_powerdown,
	output reg fast_recovery_powerdown,
	output reg baseband_flush,
	output reg [1:0] operating_mode,
	output reg dual_serial_data_port_en,
	output reg gpio_port_en,
	output reg dual_serial_lsb_first,
	output reg dual_serial_early_sync,
	output reg profile_amplitude_en,
	output reg sync_clk
);

localparam ST_IDLE = 3'h0;
localparam ST_INSTR = 3'h1;
localparam ST_WDATA = 3'h2;
localparam ST_RWAIT = 3'h3;
localparam ST_RLOAD = 3'h4;
localparam ST_RDATA = 3'h5;
localparam ST_DONE = 3'h6;

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: 0 sclk, 1 cs_n, 2 sdio, 3 update, 4 tx enable, 5 pd

reg [5:0] sync1;
reg [5:0] sync2;
reg sclk_prev;
reg upd_prev;
wire [5:0] pins;

assign pins = {external_powerdown_pin, transmit_enable_pin, io_update_in,
	sdio_in, cs_n, sclk};

always @(posedge clk or posedge rst) begin
	if (rst) begin
		sync1 <= 6'h02;
		sync2 <= 6'h02;
		sclk_prev <= 1'b0;
		upd_prev <= 1'b0;
	end else begin
		sync1 <= pins;
		sync2 <= sync1;
		sclk_prev <= sync2[0];
		upd_prev <= sync2[3];
	end
end

wire sclk_rise;
wire sclk_fall;
wire cs_active;
wire sdi_bit;

assign sclk_rise = sync2[0] & ~sclk_prev;
assign sclk_fall = ~sync2[0] & sclk_prev;
assign cs_active = ~sync2[1];
assign sdi_bit = sync2[2];

////////////////////////////////////////////////////////////////////////////
// Register store

wire [63:0] active_flat;
wire [31:0] cf1;
wire [31:0] cf2;
wire [31:0] rd_data;
wire update;
reg wr_en;
reg [31:0] wr_data;
reg [7:0] instr;

assign cf1 = active_flat[31:0];
assign cf2 = active_flat[63:32];

wire [4:0] instr_addr;
wire addr_ok;

assign instr_addr = instr[`UCR_INSTR_ADDR_HI:0];
assign addr_ok = (instr_addr == `UCR_ADDR_CF1) ||
	(instr_addr == `UCR_ADDR_CF2);

ucr_reg_store #(
	.WIDTH(32),
	.WORDS(2),
	.IW(1),
	.WMASK({`UCR_CF2_WMASK, `UCR_CF1_WMASK}),
	.IMASK({`UCR_CF2_IMASK, `UCR_CF1_IMASK}),
	.RESETV({`UCR_CF2_RESET, `UCR_CF1_RESET})
) u_store (
	.clk(clk),
	.rst(rst),
	.wr_en(wr_en),
	.wr_index(instr_addr[0]),
	.wr_data(wr_data),
	.update(update),
	.rd_index(instr_addr[0]),
	.rd_data(rd_data),
	.active_flat(active_flat)
);

////////////////////////////////////////////////////////////////////////////
// Serial frame: instruction byte, then one 32-bit word

reg [2:0] state;
reg [5:0] bit_cnt;
reg [31:0] in_sh;
reg [31:0] out_sh;
reg rd_drive;
wire lsb_first;
wire three_wire;
wire [31:0] in_next;

assign lsb_first = cf1[`UCR_CF1_LSB_FIRST];
assign three_wire = cf1[`UCR_CF1_IN_ONLY];
assign in_next = lsb_first ? {sdi_bit, in_sh[31:1]} : {in_sh[30:0], sdi_bit};
assign sdio_oe = rd_drive & ~three_wire;

always @(posedge clk or posedge rst) begin
	if (rst) begin
		state <= ST_IDLE;
		bit_cnt <= 6'h00;
		in_sh <= 32'h00000000;
		out_sh <= 32'h00000000;
		instr <= 8'h00;
		wr_en <= 1'b0;
		wr_data <= 32'h00000000;
		rd_drive <= 1'b0;
		sdio_out <= 1'b0;
		sdo <= 1'b0;
	end else begin
		wr_en <= 1'b0;
		if (!cs_active) begin
			state <= ST_IDLE;
			bit_cnt <= 6'h00;
			rd_drive <= 1'b0;
			sdio_out <= 1'b0;
			sdo <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				bit_cnt <= 6'h00;
				state <= ST_INSTR;
			end
			ST_INSTR: begin
				if (sclk_rise) begin
					in_sh <= in_next;
					bit_cnt <= bit_cnt + 6'h01;
					if (bit_cnt == `UCR_INSTR_BITS - 6'h01) begin
						instr <= lsb_first ? in_next[31:24] : in_next[7:0];
						if ((lsb_first ? in_next[31] : in_next[7]) ==
							1'b1)
							state <= ST_RWAIT;
						else
							state <= ST_WDATA;
					end
				end
			end
			ST_WDATA: begin
				if (sclk_rise) begin
					in_sh <= in_next;
					bit_cnt <= bit_cnt + 6'h01;
					if (bit_cnt == `UCR_FRAME_BITS - 6'h01) begin
						wr_data <= in_next;
						wr_en <= addr_ok;
						state <= ST_DONE;
					end
				end
			end
			ST_RWAIT: begin
				// Store read data lag the captured index by one cycle
				state <= ST_RLOAD;
			end
			ST_RLOAD: begin
				out_sh <= addr_ok ? rd_data : 32'h00000000;
				sdio_out <= addr_ok & (lsb_first ? rd_data[0] :
					rd_data[31]);
				sdo <= three_wire & addr_ok & (lsb_first ? rd_data[0] :
					rd_data[31]);
				rd_drive <= 1'b1;
				bit_cnt <= 6'h01;
				state <= ST_RDATA;
			end
			ST_RDATA: begin
				if (sclk_fall && bit_cnt != `UCR_WORD_BITS) begin
					bit_cnt <= bit_cnt + 6'h01;
					out_sh <= lsb_first ? {1'b0, out_sh[31:1]} :
						{out_sh[30:0], 1'b0};
					sdio_out <= lsb_first ? out_sh[1] : out_sh[30];
					sdo <= three_wire & (lsb_first ? out_sh[1] :
						out_sh[30]);
				end
			end
			ST_DONE: begin
				// Extra clocks after the word are ignored until cs_n rises
				state <= ST_DONE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// I/O update source

reg [15:0] upd_cnt;
reg int_update;
wire int_sel;

assign int_sel = cf2[`UCR_CF2_INT_UPD];
assign io_update_oe = int_sel;
assign update = int_sel ? int_update : (sync2[3] & ~upd_prev);

always @(posedge clk or posedge rst) begin
	if (rst) begin
		upd_cnt <= 16'h0000;
		int_update <= 1'b0;
		io_update_out <= 1'b0;
	end else begin
		int_update <= 1'b0;
		if (!int_sel) begin
			upd_cnt <= 16'h0000;
		end else if (upd_cnt == UPDATE_PERIOD - 16'h0001) begin
			upd_cnt <= 16'h0000;
			int_update <= 1'b1;
		end else begin
			upd_cnt <= upd_cnt + 16'h0001;
		end
		io_update_out <= int_sel & int_update;
	end
end

////////////////////////////////////////////////////////////////////////////
// Auto power-down and sync clock

reg apd_prev;
reg [1:0] sync_div;
wire [1:0] mode;
wire apd_cond;

assign mode = cf1[`UCR_CF1_MODE_HI:`UCR_CF1_MODE_LO];
// Only the tone code disables it; interpolating DAC mode keeps it
assign apd_cond = cf1[`UCR_CF1_AUTO_PD] && (mode != `UCR_MODE_TONE) &&
	!sync2[4];

always @(posedge clk or posedge rst) begin
	if (rst) begin
		apd_prev <= 1'b0;
		sync_div <= 2'h0;
		sync_clk <= 1'b0;
	end else begin
		apd_prev <= apd_cond;
		sync_div <= (sync_div == `UCR_SYNC_DIV) ? 2'h0 :
			sync_div + 2'h1;
		// Divider runs free so re-enabling keeps its phase
		if (cf2[`UCR_CF2_SYNC_EN])
			sync_clk <= (sync_div == `UCR_SYNC_DIV) ? ~sync_clk :
				sync_clk;
		else
			sync_clk <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////
// Registered control levels

always @(posedge clk or posedge rst) begin
	if (rst) begin
		output_shift_keying_en <= 1'b0;
		output_shift_keying_auto <= 1'b0;
		core_clock_stop <= 1'b0;
		dac_powerdown <= 1'b0;
		reference_clock_input_powerdown <= 1'b0;
		aux_dac_powerdown <= 1'b0;
		full_powerdown <= 1'b0;
		fast_recovery_powerdown <= 1'b0;
		baseband_flush <= 1'b0;
		operating_mode <= `UCR_MODE_QUAD;
		dual_serial_data_port_en <= 1'b0;
		gpio_port_en <= 1'b0;
		dual_serial_lsb_first <= 1'b0;
		dual_serial_early_sync <= 1'b0;
		profile_amplitude_en <= 1'b0;
	end else begin
		output_shift_keying_en <= cf1[`UCR_CF1_OSK_EN];
		output_shift_keying_auto <= cf1[`UCR_CF1_OSK_EN] &
			cf1[`UCR_CF1_OSK_AUTO];
		// Flush goes first; clocks stop one cycle later
		core_clock_stop <= cf1[`UCR_CF1_DIG_PD] |
			(apd_cond & apd_prev);
		baseband_flush <= apd_cond & ~apd_prev;
		dac_powerdown <= cf1[`UCR_CF1_DAC_PD];
		reference_clock_input_powerdown <= cf1[`UCR_CF1_REF_PD];
		aux_dac_powerdown <= cf1[`UCR_CF1_AUX_PD];
		full_powerdown <= sync2[5] & ~cf1[`UCR_CF1_EXT_FAST];
		fast_recovery_powerdown <= sync2[5] & cf1[`UCR_CF1_EXT_FAST];
		operating_mode <= mode;
		dual_serial_data_port_en <= cf2[`UCR_CF2_DUAL_EN] &
			(mode == `UCR_MODE_QUAD);
		gpio_port_en <= cf2[`UCR_CF2_DUAL_EN] &
			(mode == `UCR_MODE_QUAD);
		dual_serial_lsb_first <= cf2[`UCR_CF2_DUAL_EN] &
			(mode == `UCR_MODE_QUAD) & cf2[`UCR_CF2_DUAL_LSB];
		dual_serial_early_sync <= cf2[`UCR_CF2_DUAL_EN] &
			(mode == `UCR_MODE_QUAD) & cf2[`UCR_CF2_DUAL_EARLY];
		profile_amplitude_en <= cf2[`UCR_CF2_PROF_ASF] &
			(mode == `UCR_MODE_TONE) & ~cf1[`UCR_CF1_OSK_EN];
	end
end

endmodule // ucr_control_top

// File: test/ucr_control_asserts.sv
/*
 Checker for the control bank outputs.
 Assumes it is bound into ucr_control_top by the bench.
*/
`timescale 1ns/100ps
module ucr_control_asserts (
	input wire clk,
	input wire rst,
	input wire cs_n,
	input wire sdio_oe,
	input wire sdo,
	input wire io_update_out,
	input wire io_update_oe,
	input wire output_shift_keying_en,
	input wire output_shift_keying_auto,
	input wire core_clock_stop,
	input wire baseband_flush,
	input wire [1:0] operating_mode,
	input wire dual_serial_data_port_en,
	input wire gpio_port_en,
	input wire profile_amplitude_en,
	input wire sync_clk
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////
	osk_auto_a: assert property (
		output_shift_keying_auto |-> output_shift_keying_en
	) else $error("auto keying while off");
	gpio_pair_a: assert property (
		gpio_port_en == dual_serial_data_port_en
	) else $error("gpio and dual port differ");
	dual_mode_a: assert property (
		dual_serial_data_port_en |-> operating_mode == 2'h0
	) else $error("dual port outside quadrature");
	prof_amp_a: assert property (
		profile_amplitude_en |->
		operating_mode == 2'h1 && !output_shift_keying_en
	) else $error("profile amplitude wrongly on");
	flush_stop_a: assert property (
		baseband_flush |=> core_clock_stop && !baseband_flush
	) else $error("flush not followed by stop");
	flush_mode_a: assert property (
		baseband_flush |-> operating_mode != 2'h1
	) else $error("flush in single tone");
	upd_dir_a: assert property (
		!io_update_oe [*3] |-> !io_update_out
	) else $error("update driven while input");
	sdo_oe_a: assert property (
		sdo |-> !sdio_oe
	) else $error("data pin driven in 3-wire");
	oe_idle_a: assert property (
		cs_n [*5] |-> !sdio_oe
	) else $error("data pin driven while idle");
	sync_rate_a: assert property (
		$rose(sync_clk) |=> (!$rose(sync_clk)) [*3]
	) else $error("sync clock too fast");
	cover property (baseband_flush);
	cover property (dual_serial_data_port_en);
	cover property (io_update_out);
	cover property (sdio_oe);
endmodule // ucr_control_asserts

// File: test/ucr_host.sv
/*
 Host model of the serial port: 8 instruction then 32 data bits.
 Assumes clk at 40 ns; the bench resolves the data wire.
*/
`timescale 1ns/100ps
module ucr_host (
	input wire clk,
	input wire sdio_oe,
	input wire sdio_out,
	input wire sdo,
	output reg sclk,
	output reg cs_n,
	output reg sdio_drv
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdio_drv = 1'b0;
	end
	task hold;
		begin
			repeat (4) @(posedge clk);
			#1;
		end
	endtask
	// A short n aborts the frame
	task xfer(input [7:0] ins, input [31:0] d, input lsb, input [5:0] n,
		output [31:0] q);
		reg [39:0] f;
		integer i;
		begin
			f = {ins, d};
			q = 32'h00000000;
			cs_n = 1'b0;
			for (i = 0; i < n; i = i + 1) begin
				if (ins[7] && i > 7)
					sdio_drv = ~sdio_drv;
				else
					sdio_drv = lsb ? f[i < 8 ? 32 + i : i - 8] : f[39 - i];
				@(posedge clk);
				#1;
				// Read bits settle a few clk after a rise or fall;
				// take the previous bit one clk into the low phase
				if (ins[7] && i > 7)
					q[lsb ? i - 8 : 39 - i] = sdio_oe ? sdio_out : sdo;
				repeat (3) @(posedge clk);
				#1;
				sclk = 1'b1;
				hold;
				sclk = 1'b0;
			end
			hold;
			cs_n = 1'b1;
			hold;
			hold;
		end
	endtask
endmodule // ucr_host

// File: test/tb_ucr_control_top.sv
/*
 Bench for the control bank: frames through the host model, update
 pulses and pin levels. Assumes the header's field layout.
*/
`timescale 1ns/100ps
module tb_ucr_control_top;
	reg clk, rst, upd_drv, transmit_enable_pin, external_powerdown_pin;
	reg lsb, f, s;
	reg [31:0] q;
	integer err_count, samples_checked, i;
	wire sclk, cs_n, sdio_drv, sdio_out, sdio_oe, sdo, sdio_w, upd_w;
	wire io_update_out, io_update_oe, output_shift_keying_en, sync_clk;
	wire output_shift_keying_auto, core_clock_stop, dac_powerdown;
	wire reference_clock_input_powerdown, aux_dac_powerdown, full_powerdown;
	wire fast_recovery_powerdown, baseband_flush, dual_serial_data_port_en;
	wire gpio_port_en, dual_serial_lsb_first, dual_serial_early_sync;
	wire profile_amplitude_en;
	wire [1:0] operating_mode;
	wire [7:0] pw = {output_shift_keying_en, output_shift_keying_auto,
		core_clock_stop, dac_powerdown, reference_clock_input_powerdown, aux_dac_powerdown,
		full_powerdown, fast_recovery_powerdown};
	wire [5:0] dv = {dual_serial_data_port_en, gpio_port_en,
		dual_serial_lsb_first, dual_serial_early_sync,
		profile_amplitude_en, io_update_oe};
	assign sdio_w = sdio_oe ? sdio_out : sdio_drv;
	assign upd_w = io_update_oe ? io_update_out : upd_drv;
	ucr_host i_host (.clk, .sdio_oe, .sdio_out, .sdo, .sclk, .cs_n,
		.sdio_drv);
	ucr_control_top #(.UPDATE_PERIOD(16'h0004)) i_dut (.clk, .rst,
		.sclk, .cs_n, .sdio_in(sdio_w), .sdio_out, .sdio_oe, .sdo,
		.io_update_in(upd_w), .io_update_out, .io_update_oe,
		.transmit_enable_pin, .external_powerdown_pin,
		.output_shift_keying_en, .output_shift_keying_auto,
		.core_clock_stop, .dac_powerdown, .reference_clock_input_powerdown,
		.aux_dac_powerdown, .full_powerdown, .fast_recovery_powerdown,
		.baseband_flush, .operating_mode, .dual_serial_data_port_en,
		.gpio_port_en, .dual_serial_lsb_first, .dual_serial_early_sync,
		.profile_amplitude_en, .sync_clk);
	////////////////
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task chk(input [31:0] v, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (v !== e) begin
				err_count = err_count + 1;
				$display("Error at %0t: saw %h, want %h", $time, v, e);
			end
		end
	endtask
	task wr(input [4:0] a, input [31:0] d);
		i_host.xfer({3'h0, a}, d, lsb, 6'h28, q);
	endtask
	task rd(input [4:0] a, input [31:0] e);
		begin
			i_host.xfer({3'h4, a}, 32'h00000000, lsb, 6'h28, q);
			chk(q, e);
		end
	endtask
	task upd;
		begin
			upd_drv = 1'b1;
			tick(4);
			upd_drv = 1'b0;
			tick(4);
		end
	endtask
	task finish_test;
		begin
			$display("Checks %0d, mismatches %0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		upd_drv = 1'b0;
		transmit_enable_pin = 1'b1;
		external_powerdown_pin = 1'b0;
		lsb = 1'b0;
		err_count = 0;
		samples_checked = 0;
		tick(20);
		rst = 1'b0;
		tick(4);
		rd(5'h00, 32'h00000000);
		rd(5'h01, 32'h00400000);
		chk(pw, 8'h00);
		for (i = 0; i < 3; i = i + 1) begin
			s = sync_clk;
			tick(2);
			chk(sync_clk ^ s, 1'b1);
		end
		wr(5'h00, 32'hFFFFFCF0);
		tick(3);
		chk(pw, 8'h28);
		chk(reference_clock_input_powerdown, 1'b1);
		rd(5'h00, 32'h030000F0);
		upd;
		chk(pw, 8'h3C);
		chk(operating_mode, 2'h3);
		wr(5'h00, 32'h01000300);
		upd;
		chk(pw, 8'hC0);
		wr(5'h01, 32'hFFFFFFFF);
		chk(dv, 6'h01);
		rd(5'h01, 32'hE1C00000);
		wr(5'h00, 32'h01000000);
		tick(10);
		chk(dv, 6'h03);
		wr(5'h00, 32'h00000000);
		tick(10);
		chk(dv, 6'h3D);
		chk(pw, 8'h00);
		wr(5'h00, 32'h02000000);
		tick(10);
		chk(dv, 6'h01);
		wr(5'h01, 32'h00000000);
		upd;
		chk(dv, 6'h00);
		for (i = 0; i < 8; i = i + 1) begin
			tick(1);
			chk(sync_clk, 1'b0);
		end
		external_powerdown_pin = 1'b1;
		tick(5);
		chk(pw, 8'h02);
		wr(5'h00, 32'h00000008);
		upd;
		chk(pw, 8'h01);
		external_powerdown_pin = 1'b0;
		wr(5'h00, 32'h00000004);
		upd;
		transmit_enable_pin = 1'b0;
		f = 1'b0;
		for (i = 0; i < 10 && !f; i = i + 1) begin
			tick(1);
			f = baseband_flush === 1'b1;
		end
		chk(f, 1'b1);
		if (!f)
			finish_test;
		tick(1);
		chk(core_clock_stop, 1'b1);
		transmit_enable_pin = 1'b1;
		tick(6);
		chk(core_clock_stop, 1'b0);
		wr(5'h00, 32'h01000004);
		upd;
		transmit_enable_pin = 1'b0;
		tick(8);
		chk(core_clock_stop, 1'b0);
		transmit_enable_pin = 1'b1;
		wr(5'h07, 32'hFFFFFFFF);
		rd(5'h07, 32'h00000000);
		i_host.xfer(8'h00, 32'hFFFFFFFF, lsb, 6'h14, q);
		rd(5'h00, 32'h01000004);
		wr(5'h00, 32'h00000003);
		upd;
		lsb = 1'b1;
		rd(5'h00, 32'h00000003);
		wr(5'h01, 32'h20000000);
		rd(5'h01, 32'h20000000);
		finish_test;
	end
endmodule // tb_ucr_control_top
bind ucr_control_top ucr_control_asserts i_chk (.clk, .rst, .cs_n,
	.sdio_oe, .sdo, .io_update_out, .io_update_oe, .output_shift_keying_en,
	.output_shift_keying_auto, .core_clock_stop, .baseband_flush,
	.operating_mode, .dual_serial_data_port_en, .gpio_port_en,
	.profile_amplitude_en, .sync_clk);
